// ---- design/dac_ctrl_pkg.sv ----
// constants for the parallel dac control register logic
package dac_ctrl_pkg;
	localparam int          DATA_W        = 10;
	localparam int          MAIN_W        = 10;
	localparam int          SUB_W         = 8;
	localparam int          CHANNELS      = 8;
	localparam int          ADDR_W        = 3;
	// global control fields (bit positions of the written word)
	localparam int          GC_FORMAT     = 7;
	localparam int          GC_CODING     = 6;
	localparam int          GC_PWRDN_N    = 5;
	localparam int          GC_STANDBY    = 4;
	localparam int          GC_CLEAR      = 3;
	// per channel control fields
	localparam int          CC_BIAS_MSB   = 9;
	localparam int          CC_BIAS_LSB   = 8;
	localparam int          CC_MAIN_SUB   = 7;
	localparam int          CC_STANDBY_N  = 4;
	localparam int          CC_CLEAR      = 3;
	// byte mode hardware control lines
	localparam int          BYTE_HALF     = 1;
	localparam int          BYTE_TARGET   = 0;
	// reset values
	localparam logic        RST_PWRDN_N   = 1'h1;
	localparam logic        RST_STANDBY   = 1'h1;
	localparam logic        RST_FORMAT    = 1'h0;
	localparam logic        RST_CODING    = 1'h1;
	localparam logic        RST_CH_CHANNEL_STANDBY_N_N = 1'h1;
	localparam logic        RST_CH_CLEAR  = 1'h1;
	localparam logic [1:0]  RST_BIAS      = 2'h0;
	// clear levels
	localparam logic [9:0]  MAIN_MID      = 10'h000;
	localparam logic [9:0]  MAIN_BOTTOM   = 10'h000;
	localparam logic [9:0]  MAIN_BOT_2C   = 10'h200;
	localparam logic [7:0]  SUB_MID_2C    = 8'h00;
	localparam logic [7:0]  SUB_MID_OB    = 8'h80;
endpackage

// ---- design/dac_ctrl.sv ----
// parallel host port control and data registers of a multichannel dac
`timescale 1ns/100ps
`default_nettype none
module dac_ctrl
	import dac_ctrl_pkg::*;
#(
	parameter int NUM_CH = CHANNELS
) (
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     srst,
	// host port, same clock domain
	input  wire logic                     chip_select_n,
	input  wire logic                     write_n,
	input  wire logic                     mode,
	input  wire logic [ADDR_W-1:0]        channel_addr,
	input  wire logic [DATA_W-1:0]        data_in,
	input  wire logic                     output_load_strobe_n,
	// external clear pin, asynchronous
	input  wire logic                     hw_clear_n,
	// global state to the analog side
	output logic                          power_down_n,
	output logic                          global_standby,
	output logic                          coding_select,
	output logic                          byte_mode,
	// per channel state to the analog side
	output logic [NUM_CH-1:0]             channel_standby_n,
	output logic [NUM_CH-1:0][1:0]        bias_source,
	output logic [NUM_CH-1:0][MAIN_W-1:0] main_code,
	output logic [NUM_CH-1:0][SUB_W-1:0]  sub_code
);
	if (NUM_CH < 1 || NUM_CH > (1 << ADDR_W)) begin : bad_channel_count
		$error("channel count does not fit the address");
	end

	typedef struct packed {
		logic [1:0]                 clr_sync;
		logic                       wr_prev;
		logic                       pwrdn_n;
		logic                       standby;
		logic                       coding;
		logic                       format;
		logic [NUM_CH-1:0]          ch_channel_standby_n_n;
		logic [NUM_CH-1:0]          ch_clear;
		logic [NUM_CH-1:0]          ch_sub_sel;
		logic [NUM_CH-1:0][1:0]     ch_bias;
		logic [NUM_CH-1:0][MAIN_W-1:0] main_in;
		logic [NUM_CH-1:0][SUB_W-1:0]  sub_in;
		logic [NUM_CH-1:0][MAIN_W-1:0] main_out;
		logic [NUM_CH-1:0][SUB_W-1:0]  sub_out;
	} state_t;

	state_t st;
	state_t next_st;

	logic                 write_edge;
	logic                 hw_clear;
	logic [ADDR_W-1:0]    ch;
	logic                 to_channel;
	logic                 to_sub;

	// main dac clear level tracks the coding currently chosen
	function automatic logic [MAIN_W-1:0] main_clear_level(input logic offset_binary);
		return offset_binary ? MAIN_BOTTOM : MAIN_MID;
	endfunction

	// sub dac midscale in the chosen coding, always zero contribution
	function automatic logic [SUB_W-1:0] sub_mid_level(input logic offset_binary);
		return offset_binary ? SUB_MID_OB : SUB_MID_2C;
	endfunction

	// addresses past the last channel are ignored rather than wrapped
	function automatic logic valid_ch(input logic [ADDR_W-1:0] a);
		return 32'(a) < NUM_CH;
	endfunction

	// strobe edge: the word is taken as write goes high with chip select low
	assign write_edge = write_n && !st.wr_prev && !chip_select_n;
	assign hw_clear   = !st.clr_sync[1];
	assign ch         = channel_addr;
	// line zero picks the control target in both formats, and main or sub in byte mode
	assign to_channel = data_in[BYTE_TARGET];
	assign to_sub     = st.format ? data_in[BYTE_TARGET] : st.ch_sub_sel[ch];

	always_comb begin
		next_st = st;
		// two flops on the pin; only the second is read
		next_st.clr_sync = {st.clr_sync[0], hw_clear_n};
		next_st.wr_prev  = write_n;
		if (write_edge && !mode) begin
			if (!to_channel) begin
				next_st.format  = data_in[GC_FORMAT];
				next_st.coding  = data_in[GC_CODING];
				next_st.pwrdn_n = data_in[GC_PWRDN_N];
				next_st.standby = data_in[GC_STANDBY];
				if (data_in[GC_CLEAR]) begin
					for (int i = 0; i < NUM_CH; i++) begin
						// coding level comes from the word being written
						next_st.main_in[i]  = main_clear_level(data_in[GC_CODING]);
						next_st.main_out[i] = main_clear_level(data_in[GC_CODING]);
					end
				end
			end else if (valid_ch(ch)) begin
				next_st.ch_bias[ch]    = data_in[CC_BIAS_MSB:CC_BIAS_LSB];
				next_st.ch_sub_sel[ch] = data_in[CC_MAIN_SUB];
				next_st.ch_channel_standby_n_n[ch]  = data_in[CC_STANDBY_N];
				next_st.ch_clear[ch]   = data_in[CC_CLEAR];
			end
		end else if (write_edge && mode && valid_ch(ch)) begin
			if (!st.format) begin
				if (to_sub)
					next_st.sub_in[ch] = data_in[DATA_W-1:DATA_W-SUB_W];
				else
					next_st.main_in[ch] = data_in;
			end else if (!data_in[BYTE_HALF]) begin
				if (to_sub)
					next_st.sub_in[ch] = data_in[DATA_W-1:DATA_W-SUB_W];
				else
					next_st.main_in[ch][MAIN_W-1:2] = data_in[DATA_W-1:2];
			end else if (!to_sub) begin
				next_st.main_in[ch][1:0] = data_in[3:2];
			end
		end
		// load strobe moves data into output registers, applying channel clears
		if (!output_load_strobe_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				next_st.sub_out[i] = next_st.sub_in[i];
				if (st.ch_clear[i])
					next_st.main_out[i] = main_clear_level(st.coding);
				else
					next_st.main_out[i] = next_st.main_in[i];
			end
		end
		// hardware clear wins over every data write, soft clear and load, loses only to srst, and is the only sub dac clear
		if (hw_clear) begin
			for (int i = 0; i < NUM_CH; i++) begin
				next_st.main_in[i]  = main_clear_level(st.coding);
				next_st.main_out[i] = main_clear_level(st.coding);
				next_st.sub_in[i]   = sub_mid_level(st.coding);
				next_st.sub_out[i]  = sub_mid_level(st.coding);
			end
		end
		if (srst) begin
			next_st            = '0;
			next_st.clr_sync   = 2'h3;
			next_st.wr_prev    = 1'h1;
			next_st.pwrdn_n    = RST_PWRDN_N;
			next_st.standby    = RST_STANDBY;
			next_st.format     = RST_FORMAT;
			next_st.coding     = RST_CODING;
			next_st.ch_channel_standby_n_n  = {NUM_CH{RST_CH_CHANNEL_STANDBY_N_N}};
			next_st.ch_clear   = {NUM_CH{RST_CH_CLEAR}};
			for (int i = 0; i < NUM_CH; i++) begin
				next_st.ch_bias[i]  = RST_BIAS;
				next_st.main_in[i]  = main_clear_level(RST_CODING);
				next_st.main_out[i] = main_clear_level(RST_CODING);
				next_st.sub_in[i]   = sub_mid_level(RST_CODING);
				next_st.sub_out[i]  = sub_mid_level(RST_CODING);
			end
		end
	end

	always_ff @(posedge clock) begin
		st <= next_st;
	end

	assign power_down_n      = st.pwrdn_n;
	assign global_standby    = st.standby;
	assign coding_select     = st.coding;
	assign byte_mode         = st.format;
	assign channel_standby_n = st.ch_channel_standby_n_n;
	assign bias_source       = st.ch_bias;
	assign main_code         = st.main_out;
	assign sub_code          = st.sub_out;

	// assertions
	sequence ctrl_write_s;
		write_edge && !mode;
	endsequence

	sequence global_write_s;
		ctrl_write_s ##0 !data_in[BYTE_TARGET];
	endsequence

	reset_defaults_a: assert property (@(posedge clock) srst |=> power_down_n && global_standby && channel_standby_n == {NUM_CH{1'b1}})
		else $error("reset defaults wrong");
	chan_reset_a: assert property (@(posedge clock) srst |=> st.ch_clear == {NUM_CH{1'b1}} && bias_source[0] == 2'h0)
		else $error("channel reset defaults wrong");
	global_write_a: assert property (@(posedge clock) disable iff (srst) global_write_s |=> coding_select == $past(data_in[GC_CODING]) && byte_mode == $past(data_in[GC_FORMAT]))
		else $error("global write not taken");
	power_bit_a: assert property (@(posedge clock) disable iff (srst) global_write_s |=> power_down_n == $past(data_in[GC_PWRDN_N]) && global_standby == $past(data_in[GC_STANDBY]))
		else $error("power bits not taken");
	no_write_hold_a: assert property (@(posedge clock) disable iff (srst) !write_edge && !hw_clear |=> $stable(coding_select) && $stable(channel_standby_n))
		else $error("control changed without write");
	soft_clear_sub_a: assert property (@(posedge clock) disable iff (srst) !hw_clear && output_load_strobe_n |=> $stable(sub_code))
		else $error("sub dac changed without clear or load");
	hw_clear_a: assert property (@(posedge clock) disable iff (srst) hw_clear |=> main_code[0] == main_clear_level($past(coding_select)))
		else $error("hardware clear level wrong");
	load_only_a: assert property (@(posedge clock) disable iff (srst) output_load_strobe_n && !hw_clear && !write_edge |=> $stable(main_code))
		else $error("output changed without load");

	// per channel control and data write steps
	sequence chan_write_s;
		ctrl_write_s ##0 data_in[BYTE_TARGET] && valid_ch(ch);
	endsequence

	sequence data_write_s;
		write_edge && mode && valid_ch(ch) && !hw_clear;
	endsequence

	sequence word_write_s;
		data_write_s ##0 !byte_mode;
	endsequence

	sequence byte_write_s;
		data_write_s ##0 byte_mode;
	endsequence

	sequence load_s;
		!output_load_strobe_n && !hw_clear;
	endsequence

	property chan_bias_p;
		@(posedge clock) disable iff (srst) chan_write_s |=> bias_source[$past(ch)] == $past(data_in[CC_BIAS_MSB:CC_BIAS_LSB]);
	endproperty
	chan_bias_a: assert property (chan_bias_p)
		else $error("bias source not taken");
	property chan_standby_p;
		@(posedge clock) disable iff (srst) chan_write_s |=> channel_standby_n[$past(ch)] == $past(data_in[CC_STANDBY_N]);
	endproperty
	chan_standby_a: assert property (chan_standby_p)
		else $error("channel standby not taken");
	property chan_clear_bit_p;
		@(posedge clock) disable iff (srst) chan_write_s |=> st.ch_clear[$past(ch)] == $past(data_in[CC_CLEAR]);
	endproperty
	chan_clear_bit_a: assert property (chan_clear_bit_p)
		else $error("channel clear bit not taken");
	property sub_select_p;
		@(posedge clock) disable iff (srst) chan_write_s |=> st.ch_sub_sel[$past(ch)] == $past(data_in[CC_MAIN_SUB]);
	endproperty
	sub_select_a: assert property (sub_select_p)
		else $error("main or sub select not taken");

	// data register loading in both formats
	property word_main_p;
		@(posedge clock) disable iff (srst) word_write_s ##0 !st.ch_sub_sel[ch] |=> st.main_in[$past(ch)] == $past(data_in);
	endproperty
	word_main_a: assert property (word_main_p)
		else $error("word write missed main data");
	property word_sub_p;
		@(posedge clock) disable iff (srst)
			word_write_s ##0 st.ch_sub_sel[ch] |=> st.sub_in[$past(ch)] == $past(data_in[DATA_W-1:DATA_W-SUB_W]);
	endproperty
	word_sub_a: assert property (word_sub_p)
		else $error("word write missed sub data");
	property byte_high_p;
		@(posedge clock) disable iff (srst) byte_write_s ##0 !data_in[BYTE_HALF] && !data_in[BYTE_TARGET]
			|=> st.main_in[$past(ch)][MAIN_W-1:2] == $past(data_in[DATA_W-1:2]);
	endproperty
	byte_high_a: assert property (byte_high_p)
		else $error("high byte not loaded");
	property byte_low_p;
		@(posedge clock) disable iff (srst) byte_write_s ##0 data_in[BYTE_HALF] && !data_in[BYTE_TARGET]
			|=> st.main_in[$past(ch)][1:0] == $past(data_in[3:2]);
	endproperty
	byte_low_a: assert property (byte_low_p)
		else $error("low bits not loaded");
	property byte_sub_p;
		@(posedge clock) disable iff (srst) byte_write_s ##0 !data_in[BYTE_HALF] && data_in[BYTE_TARGET]
			|=> st.sub_in[$past(ch)] == $past(data_in[DATA_W-1:DATA_W-SUB_W]);
	endproperty
	byte_sub_a: assert property (byte_sub_p)
		else $error("byte write missed sub data");
	byte_low_sub_a: assert property (@(posedge clock) disable iff (srst) byte_write_s ##0 data_in[BYTE_HALF] && data_in[BYTE_TARGET] |=> $stable(st.sub_in))
		else $error("sub data changed on low bits write");

	// clears and loads
	property soft_clear_p;
		@(posedge clock) disable iff (srst) global_write_s ##0 data_in[GC_CLEAR] && !hw_clear && output_load_strobe_n
			|=> main_code[0] == main_clear_level($past(data_in[GC_CODING]));
	endproperty
	soft_clear_a: assert property (soft_clear_p)
		else $error("soft clear level wrong");
	property load_copy_p;
		@(posedge clock) disable iff (srst) load_s ##0 !st.ch_clear[0] && !write_edge
			|=> main_code[0] == $past(st.main_in[0]) && sub_code[0] == $past(st.sub_in[0]);
	endproperty
	load_copy_a: assert property (load_copy_p)
		else $error("load did not copy data");
	property pending_clear_p;
		@(posedge clock) disable iff (srst) load_s ##0 st.ch_clear[0] |=> main_code[0] == main_clear_level($past(coding_select));
	endproperty
	pending_clear_a: assert property (pending_clear_p)
		else $error("channel clear not applied at load");
	property hw_sub_level_p;
		@(posedge clock) disable iff (srst) hw_clear |=> sub_code[0] == sub_mid_level($past(coding_select)) && st.sub_in[0] == sub_code[0];
	endproperty
	hw_sub_level_a: assert property (hw_sub_level_p)
		else $error("hardware clear sub level wrong");
	property clear_sync_p;
		@(posedge clock) disable iff (srst) !$past(srst) && !$past(srst, 2) |-> hw_clear == !$past(hw_clear_n, 2);
	endproperty
	clear_sync_a: assert property (clear_sync_p)
		else $error("clear pin not seen after two flops");
	hw_main_all_a: assert property (@(posedge clock) disable iff (srst) hw_clear |=> main_code[NUM_CH-1] == main_clear_level($past(coding_select)))
		else $error("hardware clear missed last channel");
	load_sub_a: assert property (@(posedge clock) disable iff (srst) load_s ##0 !write_edge |=> sub_code[NUM_CH-1] == $past(st.sub_in[NUM_CH-1]))
		else $error("load did not copy sub data");

	// routing of writes
	data_mode_a: assert property (@(posedge clock) disable iff (srst) write_edge && mode |=> $stable(coding_select) && $stable(bias_source) && $stable(st.ch_sub_sel))
		else $error("data write touched control");
	ctrl_no_data_a: assert property (@(posedge clock) disable iff (srst) ctrl_write_s ##0 data_in[BYTE_TARGET] && !hw_clear |=> $stable(st.main_in) && $stable(st.sub_in))
		else $error("control write touched data");
	chan_only_a: assert property (@(posedge clock) disable iff (srst) chan_write_s |=> $stable(coding_select) && $stable(byte_mode) && $stable(power_down_n))
		else $error("channel write touched global");
	global_only_a: assert property (@(posedge clock) disable iff (srst) global_write_s |=> $stable(bias_source) && $stable(channel_standby_n))
		else $error("global write touched channel");
	write_taken_a: assert property (@(posedge clock) disable iff (srst) !$past(srst) |-> write_edge == (write_n && !$past(write_n) && !chip_select_n))
		else $error("write edge detect wrong");
	idle_hold_a: assert property (@(posedge clock) disable iff (srst) chip_select_n && output_load_strobe_n && !hw_clear |=> $stable(main_code) && $stable(st.sub_in))
		else $error("state changed while deselected");
	reset_codes_a: assert property (@(posedge clock) srst |=> coding_select == RST_CODING && main_code[0] == main_clear_level(RST_CODING) && sub_code[0] == sub_mid_level(RST_CODING))
		else $error("reset codes wrong");
endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
// host side model driving the parallel write port
`timescale 1ns/100ps
`default_nettype none
module host_model
	import dac_ctrl_pkg::*;
(
	// clock
	input  wire logic         clock,
	// parallel write port
	output logic              chip_select_n,
	output logic              write_n,
	output logic              mode,
	output logic [ADDR_W-1:0] channel_addr,
	output logic [DATA_W-1:0] data_in
);
	initial begin
		chip_select_n = 1'h1;
		write_n = 1'h1;
		mode = 1'h0;
		channel_addr = 3'h0;
		data_in = 10'h000;
	end
	// strobe low one cycle, select and data held over the rising strobe
	task automatic write(input logic m, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clock);
		chip_select_n = 1'h0;
		write_n = 1'h0;
		mode = m;
		channel_addr = a;
		data_in = d;
		@(negedge clock);
		write_n = 1'h1;
		@(negedge clock);
		chip_select_n = 1'h1;
		// released bus shows the inverse so a stale value cannot pass as valid
		data_in = ~d;
		channel_addr = ~a;
		repeat (2) @(negedge clock);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_multichannel_dac_parallel_control.sv ----
// self-checking bench for the parallel dac control registers
`timescale 1ns/100ps
`default_nettype none
`define chk(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_multichannel_dac_parallel_control
	import dac_ctrl_pkg::*;
;
	logic                          clock, srst, chip_select_n, write_n, mode, output_load_strobe_n, hw_clear_n;
	logic [ADDR_W-1:0]             channel_addr;
	logic [DATA_W-1:0]             data_in;
	logic                          power_down_n, global_standby, coding_select, byte_mode;
	logic [CHANNELS-1:0]           channel_standby_n;
	logic [CHANNELS-1:0][1:0]      bias_source;
	logic [CHANNELS-1:0][MAIN_W-1:0] main_code;
	logic [CHANNELS-1:0][SUB_W-1:0]  sub_code;
	int                            failures = 0;
	int                            checked = 0;
	host_model i_host (.clock, .chip_select_n, .write_n, .mode, .channel_addr, .data_in);
	dac_ctrl #(.NUM_CH(CHANNELS)) i_dut (.clock, .srst, .chip_select_n, .write_n, .mode, .channel_addr,
		.data_in, .output_load_strobe_n, .hw_clear_n, .power_down_n, .global_standby, .coding_select,
		.byte_mode, .channel_standby_n, .bias_source, .main_code, .sub_code);
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	task automatic end_of_test();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic load();
		@(negedge clock) output_load_strobe_n = 1'h0;
		@(negedge clock) output_load_strobe_n = 1'h1;
		repeat (2) @(negedge clock);
	endtask
	task automatic t_reset();
		`chk({power_down_n, global_standby, byte_mode, coding_select}, {RST_PWRDN_N, RST_STANDBY, RST_FORMAT, RST_CODING})
		for (int c = 0; c < CHANNELS; c++) begin
			`chk({channel_standby_n[c], bias_source[c], main_code[c], sub_code[c]}, {RST_CH_CHANNEL_STANDBY_N_N, RST_BIAS, MAIN_BOTTOM, SUB_MID_OB})
		end
	endtask
	task automatic t_global();
		logic [DATA_W-1:0] w [2] = '{10'h0d0, 10'h020};
		logic [3:0]        e [2] = '{4'h7, 4'h8};
		for (int i = 0; i < 2; i++) begin
			i_host.write(1'h0, 3'h5, w[i]);
			`chk({power_down_n, global_standby, byte_mode, coding_select}, e[i])
		end
	endtask
	task automatic t_bias();
		for (int b = 0; b < 4; b++) begin
			i_host.write(1'h0, 3'h2, {b[1:0], 3'h0, b[0], 4'h1});
			`chk({bias_source[2], channel_standby_n[2], bias_source[3]}, {b[1:0], b[0], 2'h0})
		end
	endtask
	task automatic t_ten_bit();
		i_host.write(1'h0, 3'h1, 10'h011);
		i_host.write(1'h1, 3'h1, 10'h155);
		`chk(main_code[1], MAIN_BOTTOM)
		load();
		`chk(main_code[1], 10'h155)
		i_host.write(1'h0, 3'h1, 10'h091);
		i_host.write(1'h1, 3'h1, 10'h2a8);
		load();
		`chk({main_code[1], sub_code[1]}, {10'h155, 8'haa})
	endtask
	task automatic t_clears();
		i_host.write(1'h0, 3'h1, 10'h019);
		`chk(main_code[1], 10'h155)
		load();
		`chk({main_code[1], sub_code[1]}, {MAIN_MID, 8'haa})
		i_host.write(1'h0, 3'h1, 10'h011);
		i_host.write(1'h1, 3'h1, 10'h155);
		load();
		i_host.write(1'h0, 3'h0, 10'h028);
		`chk({main_code[1], sub_code[1]}, {MAIN_MID, 8'haa})
	endtask
	task automatic t_byte();
		i_host.write(1'h0, 3'h0, 10'h0a0);
		// line one set and main/sub bit set: both must be ignored here
		i_host.write(1'h0, 3'h0, 10'h193);
		`chk(bias_source[0], 2'h1)
		i_host.write(1'h1, 3'h0, 10'h2ac);
		i_host.write(1'h1, 3'h0, 10'h00e);
		i_host.write(1'h1, 3'h0, 10'h171);
		load();
		`chk({main_code[0], sub_code[0]}, {10'h2af, 8'h5c})
	endtask
	task automatic t_hw_clear();
		@(negedge clock) hw_clear_n = 1'h0;
		repeat (6) @(negedge clock);
		`chk({main_code[0], sub_code[0], main_code[1], sub_code[1]}, {MAIN_MID, SUB_MID_2C, MAIN_MID, SUB_MID_2C})
		hw_clear_n = 1'h1;
		repeat (4) @(negedge clock);
	endtask
	initial begin
		srst = 1'h1;
		output_load_strobe_n = 1'h1;
		hw_clear_n = 1'h1;
		repeat (10) @(negedge clock);
		srst = 1'h0;
		repeat (2) @(negedge clock);
		t_reset();
		// global first, then channel control, then data
		t_global();
		t_bias();
		t_ten_bit();
		t_clears();
		t_byte();
		t_hw_clear();
		end_of_test();
	end
	initial begin
		#20000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
